// >>> src/serial_adapter_host_status.sv
`timescale 1ns/1ps

module serial_adapter_host_status
	import serial_adapter_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       hw_reset_n,
	input  wire logic       bus_clock,
	input  wire logic       chip_select,
	input  wire logic       reg_select_low,
	input  wire logic       reg_select_high,
	input  wire logic       read_not_write,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe,
	output logic            interrupt_out_n,
	input  wire logic       set_ready_in_n,
	input  wire logic       carrier_detect_in_n,
	output logic            terminal_ready_out_n,
	output logic            request_send_out_n,
	input  wire logic       rx_load,
	input  wire logic [8:0] rx_frame,
	input  wire logic       rx_frame_err,
	input  wire logic       tx_load,
	output logic      [7:0] tx_data,
	output logic            tx_holding_empty,
	output logic      [7:0] command_out,
	output logic      [7:0] control_out
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [PIN_W-1:0] pins;
	logic [PIN_W-1:0] s1_q, s2_q, s3_q, pf_q, pf_d;
	assign pins = {hw_reset_n, carrier_detect_in_n, set_ready_in_n, data_in,
		read_not_write, reg_select_high, reg_select_low, chip_select,
		bus_clock};
	// A bit moves only when the second and third stages agree
	assign pf_d = (s2_q & s3_q) | (pf_q & (s2_q | s3_q));

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s1_q <= PIN_RST;
			s2_q <= PIN_RST;
			s3_q <= PIN_RST;
			pf_q <= PIN_RST;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pf_q <= pf_d;
		end
	end

	// ------------------------------------------------------------
	// Bus cycle decode
	// ------------------------------------------------------------
	logic       init, bclk_f, bclk_prev_q, bus_fall, hi_sel;
	logic       acc_cs_q, acc_rw_q;
	logic [1:0] acc_sel_q, cur_sel;
	logic [7:0] acc_data_q;
	logic       wr_acc, rd_acc;
	logic       wr_data, wr_prg, wr_command, wr_ctl, rd_data, rd_stat;

	assign init    = sys_rst | ~pf_q[P_HWRST];
	assign bclk_f  = pf_q[P_BCLK];
	assign cur_sel = {pf_q[P_RSH], pf_q[P_RSL]};
	assign hi_sel  = bclk_f & pf_q[P_CS];
	assign bus_fall = bclk_prev_q & ~bclk_f;
	// Commit at the end of the high phase, from what was latched in it
	assign wr_acc  = bus_fall & acc_cs_q & acc_rw_q;
	assign rd_acc  = bus_fall & acc_cs_q & ~acc_rw_q;
	assign wr_data = wr_acc & (acc_sel_q == SEL_DATA);
	assign wr_prg  = wr_acc & (acc_sel_q == SEL_STATUS);
	assign wr_command = wr_acc & (acc_sel_q == SEL_COMMAND);
	assign wr_ctl  = wr_acc & (acc_sel_q == SEL_CONTROL);
	assign rd_data = rd_acc & (acc_sel_q == SEL_DATA);
	assign rd_stat = rd_acc & (acc_sel_q == SEL_STATUS);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bclk_prev_q <= 1'b0;
			acc_cs_q    <= 1'b0;
			acc_rw_q    <= 1'b0;
			acc_sel_q   <= SEL_DATA;
			acc_data_q  <= 8'h00;
		end else begin
			bclk_prev_q <= bclk_f;
			if (bclk_f) begin
				acc_cs_q   <= pf_q[P_CS];
				acc_rw_q   <= pf_q[P_RW];
				acc_sel_q  <= cur_sel;
				acc_data_q <= pf_q[P_DATA_HI:P_DATA_LO];
			end
		end
	end

	// ------------------------------------------------------------
	// Command, control and word length
	// ------------------------------------------------------------
	logic [7:0] command_q, ctl_q, wl_mask;
	logic [1:0] wl_code;
	logic [3:0] wl_bits;
	logic       rx_en, tx_en, modem_en;

	assign wl_code  = ctl_q[CTL_WL_HI:CTL_WL_LO];
	assign wl_bits  = WL_BASE - {2'h0, wl_code};
	assign wl_mask  = FULL_MASK >> wl_code;
	assign rx_en    = command_q[CB_DTR] & ~command_q[CB_RXDIS];
	assign tx_en    = command_q[CB_DTR]
		& (command_q[CB_TXI_HI:CB_TXI_LO] == TXI_IRQ_ON);
	assign modem_en = command_q[CB_DTR] & ~command_q[CB_RXDIS];

	always_ff @(posedge clock) begin
		if (init) begin
			command_q <= CB_RST;
			ctl_q     <= CTL_RST;
		end else if (wr_command) begin
			command_q <= acc_data_q;
		end else if (wr_prg) begin
			command_q <= command_q & CB_PRG_CLR;
		end else if (wr_ctl) begin
			ctl_q <= acc_data_q;
		end
	end

	// ------------------------------------------------------------
	// Receive path: strip parity, check it, flag errors
	// ------------------------------------------------------------
	logic [7:0] rx_hold_q, rx_bits;
	logic       par_bit, par_err;
	logic       rx_full_q, ovr_q, frame_err_q, parity_err_q;

	assign rx_bits = rx_frame[7:0] & wl_mask;
	assign par_bit = rx_frame[wl_bits];
	// Mark and space modes skip the check
	assign par_err = command_q[CB_PAR_EN] & ~command_q[CB_PAR_M1]
		& ((^rx_bits) ^ par_bit ^ ~command_q[CB_PAR_M0]);

	always_ff @(posedge clock) begin
		if (init) begin
			rx_hold_q    <= 8'h00;
			rx_full_q    <= 1'b0;
			ovr_q        <= 1'b0;
			frame_err_q  <= 1'b0;
			parity_err_q <= 1'b0;
		end else if (rx_load && rx_full_q && !rd_data) begin
			// Unread character kept; the new one is lost
			ovr_q <= 1'b1;
		end else if (rx_load) begin
			rx_hold_q    <= rx_bits;
			rx_full_q    <= 1'b1;
			ovr_q        <= 1'b0;
			frame_err_q  <= rx_frame_err;
			parity_err_q <= par_err;
		end else if (rd_data) begin
			rx_full_q    <= 1'b0;
			ovr_q        <= 1'b0;
			frame_err_q  <= 1'b0;
			parity_err_q <= 1'b0;
		end else if (wr_prg) begin
			ovr_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Transmit holding
	// ------------------------------------------------------------
	logic [7:0] tx_hold_q;
	logic       tx_empty_q;

	always_ff @(posedge clock) begin
		if (init) begin
			tx_hold_q  <= 8'h00;
			tx_empty_q <= 1'b1;
		end else begin
			if (wr_data)
				tx_hold_q <= acc_data_q & wl_mask;
			if (tx_load)
				tx_empty_q <= 1'b1;
			else if (wr_data)
				tx_empty_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Modem inputs and interrupt flag
	// ------------------------------------------------------------
	logic dcd_q, dsr_q, lock_q, modem_chg, modem_evt;
	logic rx_cond, tx_cond, irq_q, irq_d;

	assign modem_chg = (dcd_q != pf_q[P_DCD]) | (dsr_q != pf_q[P_DSR]);
	// A change held back by the freeze fires as the status read releases it
	assign modem_evt = modem_chg & (~lock_q | rd_stat)
		& modem_en;
	assign rx_cond   = rx_full_q & rx_en;
	assign tx_cond   = tx_empty_q & tx_en;
	// Error flags are left out on purpose
	assign irq_d = (irq_q & ~rd_stat) | rx_cond | tx_cond
		| modem_evt;

	always_ff @(posedge clock) begin
		if (init) begin
			dcd_q  <= 1'b1;
			dsr_q  <= 1'b1;
			lock_q <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			irq_q <= irq_d;
			if (modem_evt)
				lock_q <= 1'b1;
			else if (rd_stat)
				lock_q <= 1'b0;
			if (!lock_q || rd_stat) begin
				dcd_q <= pf_q[P_DCD];
				dsr_q <= pf_q[P_DSR];
			end
		end
	end

	// ------------------------------------------------------------
	// Read mux and registered outputs
	// ------------------------------------------------------------
	logic [7:0] status, rd_mux;
	assign status = {irq_q, dsr_q, dcd_q, tx_empty_q, rx_full_q,
		ovr_q, frame_err_q, parity_err_q};
	assign rd_mux = (cur_sel == SEL_DATA)    ? rx_hold_q :
			(cur_sel == SEL_STATUS)  ? status :
			(cur_sel == SEL_COMMAND) ? command_q : ctl_q;

	always_ff @(posedge clock) begin
		if (init) begin
			data_out             <= 8'h00;
			data_oe              <= 1'b0;
			interrupt_out_n      <= 1'b1;
			terminal_ready_out_n <= 1'b1;
			request_send_out_n   <= 1'b1;
			tx_data              <= 8'h00;
			tx_holding_empty     <= 1'b1;
			command_out          <= CB_RST;
			control_out          <= CTL_RST;
		end else begin
			data_oe              <= hi_sel & ~pf_q[P_RW];
			data_out             <= rd_mux;
			interrupt_out_n      <= ~irq_d;
			terminal_ready_out_n <= ~command_q[CB_DTR];
			request_send_out_n   <= ~command_q[CB_ECHO]
				& (command_q[CB_TXI_HI:CB_TXI_LO] == TXI_RTS_OFF);
			tx_data              <= tx_hold_q;
			tx_holding_empty     <= tx_empty_q;
			command_out          <= command_q;
			control_out          <= ctl_q;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (init);

	sequence s_rx_enabled;
		rx_load && !rx_full_q && rx_en;
	endsequence
	sequence s_flag_pin;
		irq_q && !interrupt_out_n;
	endsequence

	rx_full_set_a: assert property (rx_load |=> rx_full_q)
		else $error("rx full not set after load");
	rx_full_clr_a: assert property (rd_data && !rx_load
		|=> !rx_full_q)
		else $error("rx full not cleared by read");
	err_clear_a: assert property (rd_data && !rx_load
		|=> !ovr_q && !frame_err_q && !parity_err_q)
		else $error("error flags survived data read");
	tx_empty_a: assert property (wr_data && !tx_load
		|=> !tx_empty_q)
		else $error("tx empty not cleared by write");
	rx_irq_a: assert property (s_rx_enabled
		|=> ##1 s_flag_pin)
		else $error("enabled rx full did not interrupt");
	irq_cause_a: assert property ($rose(irq_q)
		|-> $past(rx_cond || tx_cond || modem_evt))
		else $error("interrupt without enabled cause");
	bus_phase_a: assert property (data_oe
		|-> bclk_prev_q && acc_cs_q && !acc_rw_q)
		else $error("data driven outside selected high phase");
	modem_hold_a: assert property (lock_q && !rd_stat
		|=> $stable({dcd_q, dsr_q}))
		else $error("modem bits moved while frozen");
	modem_rearm_a: assert property (rd_stat && lock_q && modem_chg
		&& modem_en |=> irq_q && lock_q)
		else $error("pending modem change did not interrupt again");
	stat_clear_a: assert property (rd_stat && !rx_cond && !tx_cond
		&& !modem_evt |=> !irq_q && interrupt_out_n)
		else $error("status read did not clear interrupt");

endmodule // serial_adapter_host_status

// >>> src/serial_adapter_pkg.sv
package serial_adapter_pkg;

	// ------------------------------------------------------------
	// Register select codes {reg_select_high, reg_select_low}
	// ------------------------------------------------------------
	localparam logic [1:0] SEL_DATA    = 2'h0;
	localparam logic [1:0] SEL_STATUS  = 2'h1;
	localparam logic [1:0] SEL_COMMAND = 2'h2;
	localparam logic [1:0] SEL_CONTROL = 2'h3;

	// ------------------------------------------------------------
	// Synchronised pin vector layout
	// ------------------------------------------------------------
	localparam int          PIN_W      = 16;
	localparam int          P_BCLK     = 0;
	localparam int          P_CS       = 1;
	localparam int          P_RSL      = 2;
	localparam int          P_RSH      = 3;
	localparam int          P_RW       = 4;
	localparam int          P_DATA_LO  = 5;
	localparam int          P_DATA_HI  = 12;
	localparam int          P_DSR      = 13;
	localparam int          P_DCD      = 14;
	localparam int          P_HWRST    = 15;
	localparam logic [15:0] PIN_RST    = 16'hE000;

	// ------------------------------------------------------------
	// Status register bits
	// ------------------------------------------------------------
	localparam int ST_PAR  = 0;
	localparam int ST_FRM  = 1;
	localparam int ST_OVR  = 2;
	localparam int ST_RXF  = 3;
	localparam int ST_TXE  = 4;
	localparam int ST_DCD  = 5;
	localparam int ST_DSR  = 6;
	localparam int ST_IRQ  = 7;

	// ------------------------------------------------------------
	// Command and control fields
	// ------------------------------------------------------------
	localparam int          CB_DTR      = 0;
	localparam int          CB_RXDIS    = 1;
	localparam int          CB_TXI_LO   = 2;
	localparam int          CB_TXI_HI   = 3;
	localparam int          CB_ECHO     = 4;
	localparam int          CB_PAR_EN   = 5;
	localparam int          CB_PAR_M0   = 6;
	localparam int          CB_PAR_M1   = 7;
	localparam logic [1:0]  TXI_IRQ_ON  = 2'h1;
	localparam logic [1:0]  TXI_RTS_OFF = 2'h0;
	localparam int          CTL_WL_LO   = 5;
	localparam int          CTL_WL_HI   = 6;
	localparam logic [7:0]  CB_RST      = 8'h00;
	localparam logic [7:0]  CTL_RST     = 8'h00;
	localparam logic [7:0]  CB_PRG_CLR  = 8'hE0;
	localparam logic [7:0]  FULL_MASK   = 8'hFF;
	localparam logic [3:0]  WL_BASE     = 4'h8;

endpackage

// >>> verification/cpu_bus_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Processor side of the register bus
// ------------------------------------------------------------
module cpu_bus_model (
	input  wire logic       clock,
	output logic            bus_clock,
	output logic            chip_select,
	output logic            reg_select_low,
	output logic            reg_select_high,
	output logic            read_not_write,
	output logic      [7:0] data_in,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe
);
	initial begin
		bus_clock = 1'b0;
		chip_select = 1'b0;
		reg_select_low = 1'b0;
		reg_select_high = 1'b0;
		read_not_write = 1'b0;
		data_in = 8'hA5;
	end

	// Pins are held through the low phase: the device commits late,
	// after its synchroniser has seen the falling bus clock
	task automatic access(input logic cs, input logic [1:0] sel,
		input logic wr, input logic [7:0] wdata, output logic [7:0] rdata);
		@(negedge clock);
		chip_select = cs;
		{reg_select_high, reg_select_low} = sel;
		read_not_write = wr;
		data_in = wr ? wdata : ~data_in;
		bus_clock = 1'b1;
		repeat (8) @(negedge clock);
		rdata = data_oe ? data_out : 8'hXX;
		bus_clock = 1'b0;
		repeat (8) @(negedge clock);
		chip_select = 1'b0;
		data_in = ~data_in;
	endtask
endmodule // cpu_bus_model

// >>> verification/tb_serial_adapter_host_status.sv
`timescale 1ns/1ps

module tb_serial_adapter_host_status;
	import serial_adapter_pkg::*;
	typedef struct packed {
		logic [7:0] ctl;
		logic [8:0] frame;
		logic [7:0] rx;
		logic [7:0] tx;
	} row_t;

	logic       clock = 1'b0;
	logic       sys_rst = 1'b1;
	logic       hw_reset_n = 1'b1;
	logic       set_ready_in_n = 1'b1;
	logic       carrier_detect_in_n = 1'b1;
	logic       rx_load = 1'b0;
	logic [8:0] rx_frame = 9'h000;
	logic       rx_frame_err = 1'b0;
	logic       tx_load = 1'b0;
	logic       bus_clock, chip_select, reg_select_low, reg_select_high;
	logic       read_not_write, data_oe, interrupt_out_n;
	logic       terminal_ready_out_n, request_send_out_n, tx_holding_empty;
	logic [7:0] data_in, data_out, tx_data, command_out, control_out, rd;
	int         n_mismatch = 0;
	int         num_checks = 0;
	int         cycle_count = 0;
	row_t       rows [4] = '{'{8'h00, 9'h15A, 8'h5A, 8'hDB},
		'{8'h20, 9'h1FF, 8'h7F, 8'h5B}, '{8'h40, 9'h1EA, 8'h2A, 8'h1B},
		'{8'h60, 9'h1F5, 8'h15, 8'h1B}};

	always #4 clock = ~clock;

	serial_adapter_host_status dut_u (.clock(clock), .sys_rst(sys_rst),
		.hw_reset_n(hw_reset_n), .bus_clock(bus_clock),
		.chip_select(chip_select), .reg_select_low(reg_select_low),
		.reg_select_high(reg_select_high), .read_not_write(read_not_write),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.interrupt_out_n(interrupt_out_n), .set_ready_in_n(set_ready_in_n),
		.carrier_detect_in_n(carrier_detect_in_n),
		.terminal_ready_out_n(terminal_ready_out_n),
		.request_send_out_n(request_send_out_n), .rx_load(rx_load),
		.rx_frame(rx_frame), .rx_frame_err(rx_frame_err), .tx_load(tx_load),
		.tx_data(tx_data), .tx_holding_empty(tx_holding_empty),
		.command_out(command_out), .control_out(control_out));

	cpu_bus_model bus_u (.clock(clock), .bus_clock(bus_clock),
		.chip_select(chip_select), .reg_select_low(reg_select_low),
		.reg_select_high(reg_select_high), .read_not_write(read_not_write),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe));

	// ------------------------------------------------------------
	// Compare, bus and engine tasks
	// ------------------------------------------------------------
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic wr(input logic [1:0] sel, input logic [7:0] d);
		bus_u.access(1'b1, sel, 1'b1, d, rd);
	endtask

	task automatic rdreg(input logic [1:0] sel, input logic [7:0] e, input string nm);
		bus_u.access(1'b1, sel, 1'b0, 8'h00, rd);
		chk8(nm, e, rd);
	endtask

	task automatic rx_push(input logic [8:0] f, input logic err);
		@(negedge clock);
		rx_frame = f;
		rx_frame_err = err;
		rx_load = 1'b1;
		@(negedge clock);
		rx_load = 1'b0;
	endtask

	task automatic tx_push();
		@(negedge clock);
		tx_load = 1'b1;
		@(negedge clock);
		tx_load = 1'b0;
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// A hang costs one mismatch, then the normal report
	always @(posedge clock) begin
		cycle_count <= cycle_count + 1;
		if (cycle_count == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(negedge clock);
		sys_rst = 1'b0;
		repeat (4) @(negedge clock);
		chk1("irq_n", 1'b1, interrupt_out_n);
		chk1("dtr_n", 1'b1, terminal_ready_out_n);
		chk1("rts_n", 1'b1, request_send_out_n);
		rdreg(SEL_STATUS, 8'h70, "status");
		foreach (rows[i]) begin
			wr(SEL_CONTROL, rows[i].ctl);
			rdreg(SEL_CONTROL, rows[i].ctl, "control");
			wr(SEL_DATA, 8'hDB);
			chk8("tx_data", rows[i].tx, tx_data);
			chk1("tx_empty", 1'b0, tx_holding_empty);
			tx_push();
			rx_push(rows[i].frame, 1'b0);
			rdreg(SEL_STATUS, 8'h78, "status");
			rdreg(SEL_DATA, rows[i].rx, "rx_data");
			rdreg(SEL_STATUS, 8'h70, "status");
		end
		// Error flags and overrun, interrupts off
		rx_push(9'h011, 1'b1);
		rx_push(9'h022, 1'b0);
		rdreg(SEL_STATUS, 8'h7E, "status");
		chk1("irq_n", 1'b1, interrupt_out_n);
		rdreg(SEL_DATA, 8'h11, "rx_data");
		rdreg(SEL_STATUS, 8'h70, "status");
		// Odd parity with a wrong parity bit, interrupts still off
		wr(SEL_COMMAND, 8'h20);
		rx_push(9'h003, 1'b0);
		rdreg(SEL_STATUS, 8'h79, "status");
		rdreg(SEL_DATA, 8'h03, "rx_data");
		// Receive interrupt
		wr(SEL_COMMAND, 8'h01);
		chk1("dtr_n", 1'b0, terminal_ready_out_n);
		rx_push(9'h003, 1'b0);
		repeat (2) @(negedge clock);
		chk1("irq_n", 1'b0, interrupt_out_n);
		rdreg(SEL_STATUS, 8'hF8, "status");
		rdreg(SEL_DATA, 8'h03, "rx_data");
		rdreg(SEL_STATUS, 8'hF0, "status");
		// Modem change, freeze and re-interrupt
		carrier_detect_in_n = 1'b0;
		repeat (10) @(negedge clock);
		chk1("irq_n", 1'b0, interrupt_out_n);
		carrier_detect_in_n = 1'b1;
		repeat (10) @(negedge clock);
		rdreg(SEL_STATUS, 8'hD0, "status");
		rdreg(SEL_STATUS, 8'hF0, "status");
		rdreg(SEL_STATUS, 8'h70, "status");
		chk1("irq_n", 1'b1, interrupt_out_n);
		// Transmit interrupt, then modem interrupt off with receive disabled
		wr(SEL_COMMAND, 8'h05);
		chk1("rts_n", 1'b0, request_send_out_n);
		chk1("irq_n", 1'b0, interrupt_out_n);
		wr(SEL_COMMAND, 8'h0B);
		rdreg(SEL_STATUS, 8'hF0, "status");
		carrier_detect_in_n = 1'b0;
		repeat (10) @(negedge clock);
		chk1("irq_n", 1'b1, interrupt_out_n);
		rdreg(SEL_STATUS, 8'h50, "status");
		// Deselected write is ignored
		bus_u.access(1'b0, SEL_DATA, 1'b1, 8'h3C, rd);
		chk1("tx_empty", 1'b1, tx_holding_empty);
		// Program reset through a status write
		wr(SEL_COMMAND, 8'hFF);
		wr(SEL_STATUS, 8'h00);
		chk8("command", 8'hE0, command_out);
		// Pin reset in mid-run
		carrier_detect_in_n = 1'b1;
		set_ready_in_n = 1'b0;
		hw_reset_n = 1'b0;
		repeat (8) @(negedge clock);
		hw_reset_n = 1'b1;
		repeat (8) @(negedge clock);
		chk8("command", 8'h00, command_out);
		chk8("control", 8'h00, control_out);
		rdreg(SEL_STATUS, 8'h30, "status");
		end_sim();
	end
endmodule // tb_serial_adapter_host_status
